// ===== sts_pkg.sv
// Constants, states and modes of the staple and tray sequencer.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package sts_pkg;

	// Clock rate and jam supervision time.
	localparam int unsigned CLK_HZ        = 50000000;
	// Each slide or delivery step re-arms the watchdog, so long stepped moves never jam.
	localparam int unsigned JAM_TIME_US   = 400;
	localparam int unsigned JAM_CYCLES    = (CLK_HZ / 1000000) * JAM_TIME_US;

	// Step pulse generator: one motor step every STEP_CYCLES clocks.
	localparam int unsigned STEP_TIME_US  = 10;
	localparam int unsigned STEP_CYCLES   = (CLK_HZ / 1000000) * STEP_TIME_US;

	// Widths of counts and positions.
	localparam int unsigned PCNT_W        = 16;
	localparam int unsigned POS_W         = 16;

	// Values after reset.
	localparam logic [15:0] RST_COUNT     = 16'h0000;

	// Staple modes.
	typedef enum logic [1:0] {
		STS_MODE_REAR  = 2'b00,
		STS_MODE_FRONT = 2'b01,
		STS_MODE_MID   = 2'b10,
		STS_MODE_BIND  = 2'b11
	} sts_mode_type;

	// Stapler and delivery sequence states.
	typedef enum logic [4:0] {
		STS_S_RESET     = 5'h00,
		STS_S_SEEK_HOME = 5'h01,
		STS_S_TO_STBY   = 5'h02,
		STS_S_IDLE      = 5'h03,
		STS_S_CLAMP     = 5'h04,
		STS_S_WAIT_CMD  = 5'h05,
		STS_S_MOVE_OUT  = 5'h06,
		STS_S_CAM_START = 5'h07,
		STS_S_CAM_TURN  = 5'h08,
		STS_S_FEED      = 5'h09,
		STS_S_LIFT      = 5'h0A,
		STS_S_EJECT     = 5'h0B,
		STS_S_JAM       = 5'h0C,
		STS_S_CAM_HOME  = 5'h0D
	} sts_state_type;

	// Delivery tray states.
	typedef enum logic [2:0] {
		STS_T_RESET = 3'b000,
		STS_T_RAISE = 3'b001,
		STS_T_HOME  = 3'b010,
		STS_T_LOWER = 3'b011,
		STS_T_STOP  = 3'b100
	} sts_tray_type;

endpackage : sts_pkg

// ===== sts_step_gen.sv
// Step pulse source and pulse counter for one stepping motor.
// Assumes the parent pulses i_start for one cycle while o_busy is low.
`timescale 1ns/1ps

module sts_step_gen
	import sts_pkg::*;
(
	// Clock and reset.
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// Request.
	input  wire logic              i_start,
	input  wire logic [PCNT_W-1:0] i_count,
	input  wire logic              i_abort,
	// Motor side.
	output logic                   o_step,
	output logic                   o_busy,
	output logic                   o_done
);

	typedef struct packed {
		logic [31:0]       div;
		logic [PCNT_W-1:0] left;
		logic              busy;
		logic              step;
		logic              done;
	} sts_step_state_type;

	sts_step_state_type st_q;
	sts_step_state_type st_d;

	// Divider makes one step per tick; count ends the move.
	always_comb begin
		st_d      = st_q;
		st_d.step = 1'b0;
		st_d.done = 1'b0;
		if (i_abort) begin
			st_d.busy = 1'b0;
		end else if (!st_q.busy) begin
			if (i_start) begin
				st_d.busy = (i_count != RST_COUNT);
				st_d.done = (i_count == RST_COUNT);
				st_d.left = i_count;
				st_d.div  = 32'h0;
			end
		end else if (st_q.div == STEP_CYCLES - 1) begin
			st_d.div  = 32'h0;
			st_d.step = 1'b1;
			st_d.left = st_q.left - 1'b1;
			if (st_q.left == 1) begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
			end
		end else begin
			st_d.div = st_q.div + 32'h1;
		end
	end

	// State register.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_step = st_q.step;
	assign o_busy = st_q.busy;
	assign o_done = st_q.done;

endmodule : sts_step_gen

// ===== sts_tray.sv
// Delivery tray controller: homes, lowers per stack, limits.
// Assumes sensors are synchronous and active high.
`timescale 1ns/1ps

module sts_tray
	import sts_pkg::*;
(
	// Clock and reset.
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// Sequencing.
	input  wire logic              i_stack_landed,
	input  wire logic [PCNT_W-1:0] i_descent_pulses,
	// Sensors.
	input  wire logic              i_tray_home_sensor,
	input  wire logic              i_shift_pulse_sensor,
	input  wire logic              i_tray_upper_limit_sensor,
	input  wire logic              i_tray_lower_limit_sensor,
	// Motor.
	output logic                   o_tray_up,
	output logic                   o_tray_down,
	output logic                   o_tray_ready
);

	typedef struct packed {
		sts_tray_type      st;
		logic [PCNT_W-1:0] left;
		logic              pulse_prev;
	} sts_tray_state_type;

	sts_tray_state_type t_q;
	sts_tray_state_type t_d;
	logic               pulse_edge;

	assign pulse_edge = i_shift_pulse_sensor & ~t_q.pulse_prev;

	// Tray sequence; the home sensor sees the paper top or the tray edge.
	always_comb begin
		t_d            = t_q;
		t_d.pulse_prev = i_shift_pulse_sensor;
		case (t_q.st)
			STS_T_RESET: begin
				t_d.st = STS_T_RAISE;
			end
			STS_T_RAISE: begin
				if (i_tray_home_sensor || i_tray_upper_limit_sensor) begin
					t_d.st = STS_T_HOME;
				end
			end
			STS_T_HOME: begin
				if (i_stack_landed) begin
					t_d.st   = STS_T_LOWER;
					t_d.left = i_descent_pulses;
				end
			end
			STS_T_LOWER: begin
				if (i_tray_lower_limit_sensor) begin
					t_d.st = STS_T_STOP;
				end else if (t_q.left == RST_COUNT) begin
					t_d.st = STS_T_RAISE;
				end else if (pulse_edge) begin
					t_d.left = t_q.left - 1'b1;
				end
			end
			STS_T_STOP: begin
				t_d.st = STS_T_RAISE;
			end
			default: begin
				t_d.st = STS_T_RESET;
			end
		endcase
	end

	// State register.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign o_tray_up    = (t_q.st == STS_T_RAISE) &
	                      ~i_tray_upper_limit_sensor;
	assign o_tray_down  = (t_q.st == STS_T_LOWER) &
	                      ~i_tray_lower_limit_sensor;
	assign o_tray_ready = (t_q.st == STS_T_HOME);

	property p_lower_stop;
		@(posedge i_clock) disable iff (i_rst)
		i_tray_lower_limit_sensor |-> !o_tray_down;
	endproperty
	a_lower_stop: assert property (p_lower_stop)
		else $error("Tray lowered past lower limit.");

	property p_upper_stop;
		@(posedge i_clock) disable iff (i_rst)
		i_tray_upper_limit_sensor |-> !o_tray_up;
	endproperty
	a_upper_stop: assert property (p_upper_stop)
		else $error("Tray raised past upper limit.");

endmodule : sts_tray

// ===== sts_sequencer.sv
// Staple and tray sequencer: stapler slide, cam, swing guide, delivery.
// Assumes one clock, synchronous sensors, host pulses one cycle wide.
//
// Behaviour
// - At power-up slide stapler frontwards until slide home sensor sees it.
// - From slide home, step configured pulses to rear standby, then stand by.
// - Stapler waits at rear standby regardless of mode or paper size.
// - When stack is aligned, paddle motor reverse lowers swing guide to clamp.
// - Host issues staple command after stacking; stapler moves per mode.
// - Rear single-point mode staples at standby without moving.
// - Front and middle modes move out and back for every staple.
// - Middle and bind modes staple rear position first, then front.
// - Each staple turns the cam exactly one revolution, home by cam sensor.
// - Cam off home: run staple motor forward until cam home sensor on.
// - Never energise staple motor while safety switch reads off.
// - Watch staple empty sensor for cartridge and staple presence.
// - Watch staple top sensor for staples pushed up to the top.
// - After stapling, delivery motor forward until belt home sensor goes off.
// - Then lift guide by pulses, return stapler, drive delivery again to eject; the stapler is returned before the feed instead.
// - At power-up bring the delivery tray to home.
// - Tray home is paper top surface, or tray edge when empty.
// - After a stack lands, lower tray configured pulses, then raise home.
// - Count shift motor travel by shift pulse sensor pulses.
// - Stop raising shift motor when upper limit sensor turns on.
// - Stop lowering shift motor when lower limit sensor turns on.
// - Sensor not reached in time: declare jam, halt, report to host; tray sensors are not timed and tray motors are not halted.
`timescale 1ns/1ps

module sts_sequencer
	import sts_pkg::*;
(
	// Clock and reset.
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// Host commands and configuration.
	input  wire logic              i_stack_aligned,
	input  wire logic              i_staple_cmd,
	input  wire logic [1:0]        i_staple_mode,
	input  wire logic              i_jam_clear,
	input  wire logic [PCNT_W-1:0] i_standby_pulses,
	input  wire logic [PCNT_W-1:0] i_front_pos_pulses,
	input  wire logic [PCNT_W-1:0] i_mid_rear_pulses,
	input  wire logic [PCNT_W-1:0] i_mid_front_pulses,
	input  wire logic [PCNT_W-1:0] i_lift_pulses,
	input  wire logic [PCNT_W-1:0] i_descent_pulses,
	// Stapler sensors.
	input  wire logic              i_slide_home_sensor,
	input  wire logic              i_staple_cam_home_sensor,
	input  wire logic              i_staple_empty_sensor,
	input  wire logic              i_staple_top_sensor,
	input  wire logic              i_staple_safety_switch,
	input  wire logic              i_guide_home_sensor,
	input  wire logic              i_belt_home_sensor,
	// Tray sensors.
	input  wire logic              i_tray_home_sensor,
	input  wire logic              i_shift_pulse_sensor,
	input  wire logic              i_tray_upper_limit_sensor,
	input  wire logic              i_tray_lower_limit_sensor,
	// Motor drives.
	output logic                   o_slide_step,
	output logic                   o_slide_to_front,
	output logic                   o_slide_run,
	output logic                   o_staple_fold_motor,
	output logic                   o_paddle_motor_rev,
	output logic                   o_delivery_step,
	output logic                   o_delivery_fwd,
	output logic                   o_tray_up,
	output logic                   o_tray_down,
	// Status to host.
	output logic                   o_standby,
	output logic                   o_busy,
	output logic                   o_jam,
	output logic                   o_staple_empty,
	output logic                   o_staple_not_top,
	output logic                   o_tray_ready
);

	////////////////////////////////////////////////////////////////////////
	// State record.

	typedef struct packed {
		sts_state_type     st;
		sts_state_type     after_move;
		logic [1:0]        mode;
		logic              second;
		logic              returning;
		logic [31:0]       watchdog;
		logic              jam;
		logic              landed;
		logic              empty;
		logic              not_top;
		logic              cam_left;
		logic              slide_front;
	} sts_seq_state_type;

	sts_seq_state_type s_q;
	sts_seq_state_type s_d;

	// Stepper requests.
	logic              slide_start;
	logic [PCNT_W-1:0] slide_count;
	logic              slide_busy;
	logic              slide_done;
	logic              del_start;
	logic [PCNT_W-1:0] del_count;
	logic              del_busy;
	logic              del_done;
	logic              abort;
	logic              cam_ok;

	// Target pulse count for the current stapling position.
	function automatic logic [PCNT_W-1:0] pos_pulses(
		input logic [1:0] mode,
		input logic       second,
		input logic [PCNT_W-1:0] front,
		input logic [PCNT_W-1:0] mrear,
		input logic [PCNT_W-1:0] mfront
	);
		logic [PCNT_W-1:0] r;
		r = front;
		if (mode == STS_MODE_MID || mode == STS_MODE_BIND) begin
			r = second ? mfront : mrear;
		end
		return r;
	endfunction : pos_pulses

	////////////////////////////////////////////////////////////////////////
	// Stepping motor drivers.

	assign abort = s_q.jam;

	sts_step_gen u_slide (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_start (slide_start),
		.i_count (slide_count),
		.i_abort (abort),
		.o_step  (o_slide_step),
		.o_busy  (slide_busy),
		.o_done  (slide_done)
	);

	sts_step_gen u_delivery (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_start (del_start),
		.i_count (del_count),
		.i_abort (abort),
		.o_step  (o_delivery_step),
		.o_busy  (del_busy),
		.o_done  (del_done)
	);

	sts_tray u_tray (
		.i_clock                   (i_clock),
		.i_rst                     (i_rst),
		.i_stack_landed            (s_q.landed),
		.i_descent_pulses          (i_descent_pulses),
		.i_tray_home_sensor        (i_tray_home_sensor),
		.i_shift_pulse_sensor      (i_shift_pulse_sensor),
		.i_tray_upper_limit_sensor (i_tray_upper_limit_sensor),
		.i_tray_lower_limit_sensor (i_tray_lower_limit_sensor),
		.o_tray_up                 (o_tray_up),
		.o_tray_down               (o_tray_down),
		.o_tray_ready              (o_tray_ready)
	);

	////////////////////////////////////////////////////////////////////////
	// Main sequence.

	// Stepper starts are pulses on the entry into the stepping states.
	always_comb begin
		s_d          = s_q;
		s_d.landed   = 1'b0;
		slide_start  = 1'b0;
		slide_count  = i_standby_pulses;
		del_start    = 1'b0;
		del_count    = i_lift_pulses;
		s_d.empty    = i_staple_empty_sensor;
		s_d.not_top  = ~i_staple_top_sensor;
		// A step proves the motor moves; only a stall should jam.
		s_d.watchdog = (o_slide_step | o_delivery_step) ? 32'h0
		                                                 : s_q.watchdog + 32'h1;
		case (s_q.st)
			STS_S_RESET: begin
				s_d.st          = STS_S_SEEK_HOME;
				s_d.slide_front = 1'b1;
				s_d.watchdog    = 32'h0;
			end
			STS_S_SEEK_HOME: begin
				if (i_slide_home_sensor) begin
					slide_start     = 1'b1;
					slide_count     = i_standby_pulses;
					s_d.slide_front = 1'b0;
					s_d.after_move  = STS_S_IDLE;
					s_d.st          = STS_S_TO_STBY;
				end
			end
			STS_S_TO_STBY: begin
				if (slide_done) begin
					s_d.st       = s_q.after_move;
					s_d.watchdog = 32'h0;
				end
			end
			STS_S_IDLE: begin
				s_d.watchdog = 32'h0;
				if (!i_staple_cam_home_sensor && i_staple_safety_switch) begin
					s_d.st = STS_S_CAM_HOME;
				end else if (i_stack_aligned) begin
					s_d.st = STS_S_CLAMP;
				end
			end
			STS_S_CAM_HOME: begin
				if (i_staple_cam_home_sensor || !i_staple_safety_switch) begin
					s_d.st = STS_S_IDLE;
				end
			end
			STS_S_CLAMP: begin
				if (!i_guide_home_sensor && i_staple_safety_switch) begin
					s_d.st       = STS_S_WAIT_CMD;
					s_d.watchdog = 32'h0;
				end
			end
			STS_S_WAIT_CMD: begin
				s_d.watchdog = 32'h0;
				if (i_staple_cmd) begin
					s_d.mode   = i_staple_mode;
					s_d.second = 1'b0;
					if (i_staple_mode == STS_MODE_REAR) begin
						s_d.st = STS_S_CAM_START;
					end else begin
						slide_start     = 1'b1;
						slide_count     = pos_pulses(i_staple_mode, 1'b0,
							i_front_pos_pulses, i_mid_rear_pulses,
							i_mid_front_pulses);
						s_d.slide_front = 1'b1;
						s_d.st          = STS_S_MOVE_OUT;
					end
				end
			end
			STS_S_MOVE_OUT: begin
				if (slide_done) begin
					// A return always ends in FEED, which then picks
					// the second point or the stack feed.
					s_d.st       = s_q.returning ? STS_S_FEED
					                             : STS_S_CAM_START;
					s_d.returning = 1'b0;
					s_d.watchdog = 32'h0;
				end
			end
			STS_S_CAM_START: begin
				if (!i_staple_cam_home_sensor) begin
					s_d.st       = STS_S_CAM_TURN;
					s_d.watchdog = 32'h0;
				end
			end
			STS_S_CAM_TURN: begin
				if (i_staple_cam_home_sensor) begin
					s_d.watchdog = 32'h0;
					if (s_q.mode == STS_MODE_REAR) begin
						s_d.st = STS_S_FEED;
					end else begin
						slide_start     = 1'b1;
						slide_count     = pos_pulses(s_q.mode, s_q.second,
							i_front_pos_pulses, i_mid_rear_pulses,
							i_mid_front_pulses);
						s_d.slide_front = 1'b0;
						s_d.returning   = 1'b1;
						s_d.second      = 1'b1;
						s_d.after_move  = (s_q.second ||
							s_q.mode == STS_MODE_FRONT) ? STS_S_FEED
							                            : STS_S_WAIT_CMD;
						s_d.st          = STS_S_MOVE_OUT;
					end
				end
			end
			STS_S_FEED: begin
				if (s_q.after_move == STS_S_WAIT_CMD) begin
					// Second point of a middle or bind staple: go out to front.
					slide_start     = 1'b1;
					slide_count     = pos_pulses(s_q.mode, 1'b1,
						i_front_pos_pulses, i_mid_rear_pulses,
						i_mid_front_pulses);
					s_d.slide_front = 1'b1;
					s_d.after_move  = STS_S_FEED;
					s_d.st          = STS_S_MOVE_OUT;
				end else if (!i_belt_home_sensor) begin
					del_start    = 1'b1;
					del_count    = i_lift_pulses;
					s_d.st       = STS_S_LIFT;
					s_d.watchdog = 32'h0;
				end
			end
			STS_S_LIFT: begin
				if (del_done) begin
					del_start    = 1'b1;
					del_count    = i_lift_pulses;
					s_d.st       = STS_S_EJECT;
					s_d.watchdog = 32'h0;
				end
			end
			STS_S_EJECT: begin
				if (del_done) begin
					s_d.landed = 1'b1;
					s_d.st     = STS_S_IDLE;
				end
			end
			STS_S_JAM: begin
				s_d.watchdog = 32'h0;
				if (i_jam_clear) begin
					s_d.jam = 1'b0;
					s_d.st  = STS_S_RESET;
				end
			end
			default: begin
				s_d.st = STS_S_RESET;
			end
		endcase
		if (s_q.st != STS_S_JAM && s_q.watchdog >= JAM_CYCLES) begin
			s_d.jam = 1'b1;
			s_d.st  = STS_S_JAM;
		end
	end

	// State register.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign cam_ok = i_staple_safety_switch & ~s_q.jam;
	assign o_staple_fold_motor = cam_ok & (s_q.st == STS_S_CAM_START ||
		s_q.st == STS_S_CAM_TURN || s_q.st == STS_S_CAM_HOME);
	// Slide, delivery, paddle and staple motors halt in the very cycle a jam is raised; the tray motors do not.
	assign o_slide_run        = ((s_q.st == STS_S_SEEK_HOME) | slide_busy) &
	                            ~s_q.jam;
	assign o_slide_to_front   = s_q.slide_front;
	assign o_paddle_motor_rev = (s_q.st == STS_S_CLAMP);
	assign o_delivery_fwd     = ((s_q.st == STS_S_FEED) | del_busy) &
	                            ~s_q.jam;
	assign o_standby          = (s_q.st == STS_S_IDLE);
	assign o_busy             = ~o_standby & ~s_q.jam;
	assign o_jam              = s_q.jam;
	assign o_staple_empty     = s_q.empty;
	assign o_staple_not_top   = s_q.not_top;

	property p_safety;
		@(posedge i_clock) disable iff (i_rst)
		!i_staple_safety_switch |-> !o_staple_fold_motor;
	endproperty
	a_safety: assert property (p_safety)
		else $error("Staple motor driven with safety open.");

	property p_rear_still;
		@(posedge i_clock) disable iff (i_rst)
		(s_q.st == STS_S_WAIT_CMD && i_staple_cmd &&
		 i_staple_mode == STS_MODE_REAR) |=> !slide_busy;
	endproperty
	a_rear_still: assert property (p_rear_still)
		else $error("Stapler moved in rear mode.");

	property p_jam;
		@(posedge i_clock) disable iff (i_rst)
		$rose(s_q.jam) |-> (s_q.st == STS_S_JAM) && !o_slide_run;
	endproperty
	a_jam: assert property (p_jam)
		else $error("Jam did not halt the sequence.");

	property p_seek;
		@(posedge i_clock) disable iff (i_rst)
		(s_q.st == STS_S_SEEK_HOME) |-> o_slide_run && o_slide_to_front;
	endproperty
	a_seek: assert property (p_seek)
		else $error("Slide not driven toward front while homing.");

	property p_clamp;
		@(posedge i_clock) disable iff (i_rst)
		(s_q.st == STS_S_IDLE && i_stack_aligned &&
		 i_staple_cam_home_sensor) |=> o_paddle_motor_rev;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("Paddle motor not reversed after alignment.");

	property p_feed;
		@(posedge i_clock) disable iff (i_rst)
		(s_q.st == STS_S_FEED) |-> o_delivery_fwd;
	endproperty
	a_feed: assert property (p_feed)
		else $error("Delivery motor idle during stack feed.");

endmodule : sts_sequencer

// ===== sts_mech_model.sv
// Mechanism model: slide, staple cam, swing guide, belt and tray.
// Assumes the sequencer's motor outputs drive it on one clock.
`timescale 1ns/1ps

module sts_mech_model (
	// Clock.
	input  wire logic i_clock,
	// Motor drives from the sequencer.
	input  wire logic i_slide_step,
	input  wire logic i_slide_to_front,
	input  wire logic i_slide_run,
	input  wire logic i_fold_motor,
	input  wire logic i_paddle_rev,
	input  wire logic i_delivery_step,
	input  wire logic i_delivery_fwd,
	input  wire logic i_tray_up,
	input  wire logic i_tray_down,
	// Sensors back to the sequencer.
	output logic      o_slide_home  = 1'b0,
	output logic      o_cam_home    = 1'b1,
	output logic      o_safety      = 1'b0,
	output logic      o_guide_home  = 1'b1,
	output logic      o_belt_home   = 1'b1,
	output logic      o_tray_home   = 1'b0,
	output logic      o_shift_pulse = 1'b0,
	output int        o_revs        = 0
);
	int seek = 0;
	int cam  = 0;
	int pad  = 0;
	int fwd  = 0;
	int tr   = 0;
	int sp   = 0;

	////////////////////////////////////////////////////////////////////////
	// Most parts take several clocks to move; slide steps, delivery steps and tray lowering change their sensors at once.
	always @(posedge i_clock) begin
		seek <= (i_slide_run && i_slide_to_front) ? seek + 1 : 0;
		if (i_slide_step && !i_slide_to_front)
			o_slide_home <= 1'b0;
		else if (seek == 20 || (i_slide_step && i_slide_to_front))
			o_slide_home <= 1'b1;
		if (i_fold_motor && o_safety) begin
			cam <= cam + 1;
			if (cam == 2)
				o_cam_home <= 1'b0;
			if (cam == 15) begin
				o_cam_home <= 1'b1;
				cam <= 0;
				o_revs <= o_revs + 1;
			end
		end
		pad <= i_paddle_rev ? pad + 1 : 0;
		if (pad == 10) begin
			o_guide_home <= 1'b0;
			o_safety <= 1'b1;
		end
		fwd <= i_delivery_fwd ? fwd + 1 : 0;
		if (fwd == 10)
			o_belt_home <= 1'b0;
		if (i_delivery_step) begin
			o_guide_home <= 1'b1;
			o_safety <= 1'b0;
			o_belt_home <= 1'b1;
		end
		tr <= i_tray_up ? tr + 1 : 0;
		if (tr == 10)
			o_tray_home <= 1'b1;
		if (i_tray_down)
			o_tray_home <= 1'b0;
		sp <= (i_tray_up || i_tray_down) ? sp + 1 : 0;
		o_shift_pulse <= sp[2];
	end

endmodule : sts_mech_model

// ===== testbench.sv
// Self-checking bench of the staple and tray sequencer with its mechanism.
// Assumes 50 MHz; steps are slow, so every pulse count is kept at one.
`timescale 1ns/1ps

module testbench;
	import sts_pkg::*;

	localparam logic [15:0] P = 16'h0001;
	logic clk = 0, rst = 1, aligned = 0, cmd = 0, empty = 0, top = 0;
	logic [1:0] mode = 2'b00;
	logic sl_h, cam_h, safe, gd_h, blt_h, tr_h, shp, e_q, t_q, r_q, sb_q, td_q;
	logic o_slide_step, o_slide_to_front, o_slide_run, o_staple_fold_motor;
	logic o_paddle_motor_rev, o_delivery_step, o_delivery_fwd, o_tray_up;
	logic o_tray_down, o_standby, o_busy, o_jam, o_staple_empty;
	logic o_staple_not_top, o_tray_ready, shp_q, armed = 0;
	logic jam_clr = 0, blk = 0;
	int revs, rev0, steps, dsteps, tp, error_cnt = 0, total_checks = 0;
	int exp_q[$];

	initial forever #10 clk = ~clk;

	sts_sequencer uut (.i_clock(clk), .i_rst(rst), .i_stack_aligned(aligned),
		.i_staple_cmd(cmd), .i_staple_mode(mode), .i_jam_clear(jam_clr),
		.i_standby_pulses(P), .i_front_pos_pulses(P), .i_mid_rear_pulses(P),
		.i_mid_front_pulses(P), .i_lift_pulses(P), .i_descent_pulses(P),
		.i_slide_home_sensor(sl_h), .i_staple_cam_home_sensor(cam_h),
		.i_staple_empty_sensor(empty), .i_staple_top_sensor(top),
		.i_staple_safety_switch(safe & ~blk), .i_guide_home_sensor(gd_h),
		.i_belt_home_sensor(blt_h), .i_tray_home_sensor(tr_h),
		.i_shift_pulse_sensor(shp), .i_tray_upper_limit_sensor(1'b0),
		.i_tray_lower_limit_sensor(1'b0), .o_slide_step(o_slide_step),
		.o_slide_to_front(o_slide_to_front), .o_slide_run(o_slide_run),
		.o_staple_fold_motor(o_staple_fold_motor),
		.o_paddle_motor_rev(o_paddle_motor_rev),
		.o_delivery_step(o_delivery_step), .o_delivery_fwd(o_delivery_fwd),
		.o_tray_up(o_tray_up), .o_tray_down(o_tray_down),
		.o_standby(o_standby), .o_busy(o_busy), .o_jam(o_jam),
		.o_staple_empty(o_staple_empty), .o_staple_not_top(o_staple_not_top),
		.o_tray_ready(o_tray_ready));

	sts_mech_model mech (.i_clock(clk), .i_slide_step(o_slide_step),
		.i_slide_to_front(o_slide_to_front), .i_slide_run(o_slide_run),
		.i_fold_motor(o_staple_fold_motor), .i_paddle_rev(o_paddle_motor_rev),
		.i_delivery_step(o_delivery_step), .i_delivery_fwd(o_delivery_fwd),
		.i_tray_up(o_tray_up), .i_tray_down(o_tray_down), .o_slide_home(sl_h),
		.o_cam_home(cam_h), .o_safety(safe), .o_guide_home(gd_h),
		.o_belt_home(blt_h), .o_tray_home(tr_h), .o_shift_pulse(shp),
		.o_revs(revs));

	////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// Flag comparison; a mismatch is reported at once.
	task automatic check(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t flag mismatch", $time);
		end
	endtask : check

	// Motion comparison: cam turns, slide and delivery steps, tray pulses.
	task automatic compare_op(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			error_cnt++;
			$display("ERROR %0t motion %0d expected %0d", $time, got, exp);
		end
	endtask : compare_op

	// Bounded wait; a stuck design would otherwise hang the run.
	task automatic wait_lvl(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 24000) begin
			@(negedge clk);
			n++;
		end
		if (s !== v) begin
			error_cnt++;
			$display("ERROR %0t wait timed out", $time);
			tally_and_finish();
		end
	endtask : wait_lvl

	////////////////////////////////////////////////////////////////////////
	// Sensor noise on the supply sensors, changed off the sampling edge.
	always @(negedge clk) begin
		empty <= 1'($urandom);
		top <= 1'($urandom);
	end

	// Watcher: counts motion since each command, scores it at standby.
	always @(posedge clk) begin
		e_q <= empty;
		t_q <= top;
		r_q <= rst;
		sb_q <= o_standby;
		td_q <= o_tray_down;
		shp_q <= shp;
		steps <= cmd ? 0 : steps + (o_slide_step === 1'b1);
		dsteps <= cmd ? 0 : dsteps + (o_delivery_step === 1'b1);
		tp <= (o_tray_down !== 1'b1) ? 0 : tp + (shp && !shp_q);
		if (cmd) begin
			armed <= 1'b1;
			rev0 <= revs;
		end
		if (!rst && !r_q) begin
			check(o_staple_empty, e_q);
			check(o_staple_not_top, !t_q);
			if (o_staple_fold_motor === 1'b1)
				check(safe & ~blk, 1'b1);
		end
		if (armed && !sb_q && o_standby === 1'b1 && exp_q.size() > 0) begin
			armed <= 1'b0;
			compare_op((revs - rev0) * 100 + steps * 10 + dsteps,
				exp_q.pop_front());
		end
		if (td_q && o_tray_down === 1'b0)
			compare_op(tp, 1);
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence: homing, a refused command, then every staple mode.
	initial begin
		mode = 2'($urandom(32'h3644B1AD));
		repeat (2) @(negedge clk);
		rst = 0;
		wait_lvl(o_standby, 1'b1);
		wait_lvl(o_tray_ready, 1'b1);
		cmd = 1;
		@(negedge clk);
		cmd = 0;
		repeat (2) @(negedge clk);
		check(o_standby, 1'b1);
		check(o_busy, 1'b0);
		check(o_jam, 1'b0);
		for (int m = 0; m < 4; m++) begin
			exp_q.push_back(((m > 1) ? 200 : 100) + m * 20 - (m == 3) * 20 + 2);
			aligned = 1;
			wait_lvl(o_paddle_motor_rev, 1'b1);
			wait_lvl(o_paddle_motor_rev, 1'b0);
			@(negedge clk);
			mode = 2'(m);
			cmd = 1;
			@(negedge clk);
			cmd = 0;
			aligned = 0;
			wait_lvl(o_standby, 1'b0);
			check(o_busy, 1'b1);
			wait_lvl(o_standby, 1'b1);
			wait_lvl(o_tray_ready, 1'b1);
		end
		// safety switch never reads on: jam, halt, clear, rehome.
		blk = 1;
		aligned = 1;
		wait_lvl(o_jam, 1'b1);
		check(o_paddle_motor_rev, 1'b0);
		check(o_busy, 1'b0);
		aligned = 0;
		jam_clr = 1;
		@(negedge clk);
		jam_clr = 0;
		blk = 0;
		wait_lvl(o_standby, 1'b1);
		check(o_jam, 1'b0);
		check(o_slide_to_front, 1'b0);
		tally_and_finish();
	end

endmodule : testbench
